// ### rtl/fcp_host.sv
// How it works
// - Write 0030h anywhere resumes a suspended erase.
// - Extra block address only within 96 us.
// - Set-lock: A8, 54, C0, word at 4n-2.
// - Code unlock writes FFFFh from flash, absolute.
// - Code relock writes FFFBh from flash, absolute.
// - Command sequences come from outside the flash.
// - Command writes use register-indirect full addresses.
// - Software clears segmentation off bit.
// - Software far-jumps after enabling flash.
// - Software reloads page pointers after remapping.
`timescale 1ns/10ps
`default_nettype none
module fcp_host #(
  parameter int P_BLK_WIN_CYC = fcp_pkg::BLK_WIN_CYC
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // AXI4-Lite slave
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output var  logic        o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output var  logic        o_wready,
  output var  logic [1:0]  o_bresp,
  output var  logic        o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output var  logic        o_arready,
  output var  logic [31:0] o_rdata,
  output var  logic [1:0]  o_rresp,
  output var  logic        o_rvalid,
  input  wire logic        i_rready,
  // Flash command interface
  output var  logic [23:0] o_fl_addr,
  output var  logic [15:0] o_fl_wdata,
  output var  logic        o_fl_we,
  output var  logic        o_fl_re,
  output var  logic        o_fl_from_flash,
  output var  logic        o_fl_absolute,
  input  wire logic [15:0] i_fl_rdata,
  // System configuration
  output var  logic        o_internal_flash_enable,
  output var  logic        o_low_window_move,
  output var  logic        o_segmentation_off
);
  import fcp_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE, S_ISSUE, S_STROBE, S_CAP, S_GAP
  } fcp_state_t;

  fcp_state_t  state_r;
  fcp_op_t     op_r;
  fcp_op_t     op_w;
  logic        start_w;
  logic [23:0] base_w;
  logic [15:0] word_w;
  logic [2:0]  scfg_w;
  logic [23:0] st_addr [4];
  logic [15:0] st_data [4];
  logic [3:0]  st_rd;
  logic [1:0]  idx_r;
  logic [1:0]  last_r;
  logic        code_op_r;
  logic        busy_r;
  logic        err_r;
  logic [15:0] rd_r;
  logic [15:0] win_cnt_r;
  logic        win_exp;
  logic        acc;
  logic        go_ok;

  function automatic logic [23:0] fn_cmd(input logic [23:0] base,
                                         input logic [13:0] off);
    return {base[23:14], off};
  endfunction : fn_cmd

  assign win_exp = win_cnt_r >= 16'(P_BLK_WIN_CYC);
  assign acc     = start_w && !busy_r && state_r == S_IDLE;
  assign go_ok   = op_w != OP_NONE && 4'(op_w) <= 4'(OP_POLL)
                   && !(op_w == OP_BLKADD && win_exp);

  // ----------------------------------------------------------------
  // Register front end
  // ----------------------------------------------------------------
  fcp_regs u_regs (
    .i_clk     (i_clk),
    .i_rst_n   (i_rst_n),
    .i_awaddr  (i_awaddr),
    .i_awvalid (i_awvalid),
    .o_awready (o_awready),
    .i_wdata   (i_wdata),
    .i_wstrb   (i_wstrb),
    .i_wvalid  (i_wvalid),
    .o_wready  (o_wready),
    .o_bresp   (o_bresp),
    .o_bvalid  (o_bvalid),
    .i_bready  (i_bready),
    .i_araddr  (i_araddr),
    .i_arvalid (i_arvalid),
    .o_arready (o_arready),
    .o_rdata   (o_rdata),
    .o_rresp   (o_rresp),
    .o_rvalid  (o_rvalid),
    .i_rready  (i_rready),
    .o_start   (start_w),
    .o_op      (op_w),
    .o_base    (base_w),
    .o_word    (word_w),
    .o_scfg    (scfg_w),
    .i_busy    (busy_r),
    .i_err     (err_r),
    .i_win     (win_exp),
    .i_rdat    (rd_r)
  );

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_internal_flash_enable <= SCFG_RST[SCFG_EN];
      o_low_window_move       <= SCFG_RST[SCFG_LOW];
      o_segmentation_off      <= SCFG_RST[SCFG_SEG];
    end else begin
      o_internal_flash_enable <= scfg_w[SCFG_EN];
      o_low_window_move       <= scfg_w[SCFG_LOW];
      o_segmentation_off      <= scfg_w[SCFG_SEG];
    end
  end

  // ----------------------------------------------------------------
  // Command table
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      op_r      <= OP_NONE;
      st_rd     <= 4'h0;
      last_r    <= 2'h0;
      code_op_r <= 1'b0;
    end else if (acc) begin
      op_r       <= op_w;
      st_rd      <= 4'h0;
      code_op_r  <= 1'b0;
      last_r     <= 2'h3;
      st_addr[0] <= fn_cmd(base_w, CA_A);
      st_data[0] <= D_UNLK1;
      st_addr[1] <= fn_cmd(base_w, CA_B);
      st_data[1] <= D_UNLK2;
      st_addr[2] <= fn_cmd(base_w, CA_A);
      st_data[2] <= D_SETLK;
      st_addr[3] <= {base_w[23:2], ODD_LOW};
      st_data[3] <= word_w;
      unique case (op_w)
        OP_SETLOCK: st_data[2] <= D_SETLK;
        OP_QUERY: begin
          st_data[2] <= D_QUERY;
          st_rd      <= 4'h8;
        end
        OP_BLKSUSP: begin
          st_data[2] <= D_BLKSUS1;
          st_addr[3] <= base_w;
          st_data[3] <= D_BLKSUS2;
        end
        OP_RESUME, OP_BLKADD: begin
          st_addr[0] <= base_w;
          st_data[0] <= D_RESUME;
          last_r     <= 2'h0;
        end
        OP_CODESUSP, OP_CODERES: begin
          st_addr[0] <= base_w;
          st_data[0] <= (op_w == OP_CODESUSP) ? D_CODESUS : D_CODERES;
          code_op_r  <= 1'b1;
          last_r     <= 2'h0;
        end
        OP_POLL: begin
          st_addr[0] <= base_w;
          st_rd      <= 4'h1;
          last_r     <= 2'h0;
        end
        default: last_r <= 2'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Cycle sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_r         <= S_IDLE;
      idx_r           <= 2'h0;
      busy_r          <= 1'b0;
      err_r           <= 1'b0;
      o_fl_we         <= 1'b0;
      o_fl_re         <= 1'b0;
      o_fl_addr       <= 24'h00_0000;
      o_fl_wdata      <= 16'h0000;
      o_fl_from_flash <= 1'b0;
      o_fl_absolute   <= 1'b0;
    end else begin
      o_fl_we <= 1'b0;
      o_fl_re <= 1'b0;
      unique case (state_r)
        S_IDLE: begin
          if (acc) begin
            err_r  <= !go_ok;
            busy_r <= go_ok;
            idx_r  <= 2'h0;
            if (go_ok) begin
              state_r <= S_ISSUE;
            end
          end
        end
        S_ISSUE: begin
          o_fl_addr       <= st_addr[idx_r];
          o_fl_wdata      <= st_data[idx_r];
          o_fl_we         <= !st_rd[idx_r];
          o_fl_re         <= st_rd[idx_r];
          o_fl_from_flash <= code_op_r;
          o_fl_absolute   <= code_op_r;
          state_r         <= S_STROBE;
        end
        S_STROBE: state_r <= st_rd[idx_r] ? S_CAP : S_GAP;
        S_CAP: state_r <= S_GAP;
        S_GAP: begin
          if (idx_r == last_r) begin
            state_r         <= S_IDLE;
            busy_r          <= 1'b0;
            o_fl_from_flash <= 1'b0;
            o_fl_absolute   <= 1'b0;
          end else begin
            idx_r   <= idx_r + 2'h1;
            state_r <= S_ISSUE;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read capture and block-address window
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rd_r <= 16'h0000;
    end else if (state_r == S_CAP) begin
      rd_r <= i_fl_rdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      win_cnt_r <= 16'(P_BLK_WIN_CYC);
    end else if (o_fl_we) begin
      win_cnt_r <= 16'h0000;
    end else if (!win_exp) begin
      win_cnt_r <= win_cnt_r + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  resume_data_a: assert property (
    (o_fl_we && (op_r == OP_RESUME || op_r == OP_BLKADD))
      |-> o_fl_wdata == D_RESUME)
    else $error("resume write carries wrong data");

  blk_window_a: assert property (
    (acc && op_w == OP_BLKADD && win_exp) |=> (err_r && !busy_r))
    else $error("late block address was not refused");

  lock_prefix_a: assert property (
    (o_fl_we && idx_r == 2'h0
      && (op_r == OP_SETLOCK || op_r == OP_QUERY || op_r == OP_BLKSUSP))
      |-> (o_fl_addr[13:0] == CA_A && o_fl_wdata == D_UNLK1))
    else $error("first unlock cycle wrong");

  setlock_len_a: assert property (
    ($rose(busy_r) && op_r == OP_SETLOCK) |-> ##11 busy_r ##1 !busy_r)
    else $error("set-lock sequence length wrong");

  odd_addr_a: assert property (
    ((o_fl_we || o_fl_re) && idx_r == 2'h3
      && (op_r == OP_SETLOCK || op_r == OP_QUERY))
      |-> o_fl_addr[1:0] == ODD_LOW)
    else $error("fourth cycle not at odd word address");

  code_susp_a: assert property (
    (o_fl_we && op_r == OP_CODESUSP)
      |-> (o_fl_wdata == D_CODESUS && o_fl_from_flash && o_fl_absolute))
    else $error("code unlock write malformed");

  code_res_a: assert property (
    (o_fl_we && op_r == OP_CODERES)
      |-> (o_fl_wdata == D_CODERES && o_fl_from_flash && o_fl_absolute))
    else $error("code relock write malformed");

  cmd_origin_a: assert property (
    ((o_fl_we || o_fl_re) && !code_op_r)
      |-> (!o_fl_from_flash && !o_fl_absolute))
    else $error("command cycle marked as flash fetch");

  strobe_gap_a: assert property (
    o_fl_we |=> (!o_fl_we && !o_fl_re) ##1 !o_fl_we)
    else $error("strobes not separated");

  query_cap_a: assert property (
    o_fl_re |-> ##2 (rd_r == $past(i_fl_rdata)))
    else $error("read data not captured");

  setlock_done_c: cover property (
    $fell(busy_r) && op_r == OP_SETLOCK && !err_r);
  query_read_c: cover property (o_fl_re && op_r == OP_QUERY);
  code_susp_c: cover property (o_fl_we && op_r == OP_CODESUSP);
  blk_refused_c: cover property (acc && op_w == OP_BLKADD && win_exp);

endmodule : fcp_host
`default_nettype wire

// ### rtl/fcp_pkg.sv
`default_nettype none
package fcp_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS      = 8;
  localparam int BLK_WIN_NS  = 96000;
  localparam int BLK_WIN_CYC = BLK_WIN_NS / CLK_NS;

  // ----------------------------------------------------------------
  // Register offsets and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ADDR = 8'h04;
  localparam logic [7:0] OFF_DATA = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0C;
  localparam logic [7:0] OFF_RDAT = 8'h10;
  localparam logic [7:0] OFF_SCFG = 8'h14;
  localparam int STAT_BUSY   = 0;
  localparam int STAT_ERR    = 1;
  localparam int STAT_WIN    = 2;
  localparam int STAT_FSB3   = 3;
  localparam int SCFG_EN     = 0;
  localparam int SCFG_LOW    = 1;
  localparam int SCFG_SEG    = 2;
  localparam int FSB_TO_BIT  = 3;
  localparam logic [2:0] SCFG_RST = 3'h6;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Command addresses and data
  // ----------------------------------------------------------------
  localparam logic [13:0] CA_A      = 14'h2A54;
  localparam logic [13:0] CA_B      = 14'h15A8;
  localparam logic [1:0]  ODD_LOW   = 2'h2;
  localparam logic [15:0] D_UNLK1   = 16'h00A8;
  localparam logic [15:0] D_UNLK2   = 16'h0054;
  localparam logic [15:0] D_SETLK   = 16'h00C0;
  localparam logic [15:0] D_QUERY   = 16'h0090;
  localparam logic [15:0] D_BLKSUS1 = 16'h00C1;
  localparam logic [15:0] D_BLKSUS2 = 16'h00F0;
  localparam logic [15:0] D_RESUME  = 16'h0030;
  localparam logic [15:0] D_CODESUS = 16'hFFFF;
  localparam logic [15:0] D_CODERES = 16'hFFFB;

  typedef enum logic [3:0] {
    OP_NONE, OP_RESUME, OP_SETLOCK, OP_QUERY, OP_BLKSUSP,
    OP_CODESUSP, OP_CODERES, OP_BLKADD, OP_POLL
  } fcp_op_t;

endpackage : fcp_pkg
`default_nettype wire

// ### rtl/fcp_regs.sv
`timescale 1ns/10ps
`default_nettype none
module fcp_regs (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  // AXI4-Lite slave
  input  wire logic [7:0]       i_awaddr,
  input  wire logic             i_awvalid,
  output var  logic             o_awready,
  input  wire logic [31:0]      i_wdata,
  input  wire logic [3:0]       i_wstrb,
  input  wire logic             i_wvalid,
  output var  logic             o_wready,
  output var  logic [1:0]       o_bresp,
  output var  logic             o_bvalid,
  input  wire logic             i_bready,
  input  wire logic [7:0]       i_araddr,
  input  wire logic             i_arvalid,
  output var  logic             o_arready,
  output var  logic [31:0]      o_rdata,
  output var  logic [1:0]       o_rresp,
  output var  logic             o_rvalid,
  input  wire logic             i_rready,
  // Orders to the sequencer
  output var  logic             o_start,
  output var  fcp_pkg::fcp_op_t o_op,
  output var  logic [23:0]      o_base,
  output var  logic [15:0]      o_word,
  output var  logic [2:0]       o_scfg,
  // Status from the sequencer
  input  wire logic             i_busy,
  input  wire logic             i_err,
  input  wire logic             i_win,
  input  wire logic [15:0]      i_rdat
);
  import fcp_pkg::*;

  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic [7:0]  wa;
  logic        wr_go;

  function automatic logic [31:0] fn_merge(input logic [31:0] old,
                                           input logic [31:0] nw,
                                           input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction : fn_merge

  assign wa    = {awaddr_r[7:2], 2'h0};
  assign wr_go = !o_awready && !o_wready && !o_bvalid;

  // ----------------------------------------------------------------
  // Write channels
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_awready <= 1'b1;
      o_wready  <= 1'b1;
      o_bvalid  <= 1'b0;
      o_bresp   <= RESP_OKAY;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
    end else begin
      if (i_awvalid && o_awready) begin
        awaddr_r  <= i_awaddr;
        o_awready <= 1'b0;
      end
      if (i_wvalid && o_wready) begin
        wdata_r  <= i_wdata;
        wstrb_r  <= i_wstrb;
        o_wready <= 1'b0;
      end
      if (wr_go) begin
        o_bvalid <= 1'b1;
        o_bresp  <= (wa > OFF_SCFG) ? RESP_SLVERR : RESP_OKAY;
      end
      if (o_bvalid && i_bready) begin
        o_bvalid  <= 1'b0;
        o_awready <= 1'b1;
        o_wready  <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register store
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_start <= 1'b0;
      o_op    <= OP_NONE;
      o_base  <= 24'h00_0000;
      o_word  <= 16'hFFFF;
      o_scfg  <= SCFG_RST;
    end else begin
      o_start <= 1'b0;
      if (wr_go) begin
        if (wa == OFF_CTRL && wstrb_r[0] && !i_busy) begin
          o_op    <= fcp_op_t'(wdata_r[3:0]);
          o_start <= 1'b1;
        end
        if (wa == OFF_ADDR) begin
          o_base <= 24'(fn_merge({8'h00, o_base}, wdata_r, wstrb_r));
        end
        if (wa == OFF_DATA) begin
          o_word <= 16'(fn_merge({16'h0000, o_word}, wdata_r, wstrb_r));
        end
        if (wa == OFF_SCFG) begin
          o_scfg <= 3'(fn_merge({29'h0, o_scfg}, wdata_r, wstrb_r));
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Read channels
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_arready <= 1'b1;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h0000_0000;
      o_rresp   <= RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b1;
      o_rresp   <= RESP_OKAY;
      unique case ({i_araddr[7:2], 2'h0})
        OFF_CTRL: o_rdata <= {28'h0, 4'(o_op)};
        OFF_ADDR: o_rdata <= {8'h00, o_base};
        OFF_DATA: o_rdata <= {16'h0000, o_word};
        OFF_STAT: o_rdata <= {28'h0, i_rdat[FSB_TO_BIT], i_win, i_err,
                              i_busy};
        OFF_RDAT: o_rdata <= {16'h0000, i_rdat};
        OFF_SCFG: o_rdata <= {29'h0, o_scfg};
        default: begin
          o_rdata <= 32'h0000_0000;
          o_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (o_rvalid && i_rready) begin
      o_rvalid  <= 1'b0;
      o_arready <= 1'b1;
    end
  end

endmodule : fcp_regs
`default_nettype wire

// ### bench/fcp_dev_model.sv
`timescale 1ns/10ps
`default_nettype none
module fcp_dev_model (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // Flash command interface
  input  wire logic [23:0] i_fl_addr,
  input  wire logic [15:0] i_fl_wdata,
  input  wire logic        i_fl_we,
  input  wire logic        i_fl_re,
  input  wire logic        i_fl_from_flash,
  input  wire logic        i_fl_absolute,
  output var  logic [15:0] o_fl_rdata
);
  import fcp_pkg::*;
  // Lock word is non-volatile: reset leaves it alone
  logic [15:0] lock_r = 16'hFFFF;
  logic [1:0]  step_r;
  logic [1:0]  mode_r;
  logic        code_open_r;
  logic        blk_open_r;
  logic        wr_err_r;
  logic        cmd_a;
  logic        cmd_b;
  logic        odd;
  logic [7:0]  lo;
  assign cmd_a = (i_fl_addr[13:0] == CA_A);
  assign cmd_b = (i_fl_addr[13:0] == CA_B);
  assign odd   = (i_fl_addr[1:0] == ODD_LOW);
  assign lo    = i_fl_wdata[7:0];
  // ------------------------------------------------------------------
  // Sequence tracking, no time-out between cycles
  // ------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      step_r      <= 2'h0;
      mode_r      <= 2'h0;
      code_open_r <= 1'b0;
      blk_open_r  <= 1'b0;
      wr_err_r    <= 1'b0;
    end else if (i_fl_we) begin
      step_r <= 2'h0;
      if (step_r == 2'h0 && cmd_a && lo == 8'hA8) begin
        step_r <= 2'h1;
      end else if (step_r == 2'h1 && cmd_b && lo == 8'h54) begin
        step_r <= 2'h2;
      end else if (step_r == 2'h2 && cmd_a) begin
        step_r <= 2'h3;
        mode_r <= (lo == 8'hC0) ? 2'h1 : (lo == 8'h90) ? 2'h2 :
                  (lo == 8'hC1) ? 2'h3 : 2'h0;
      end else if (step_r == 2'h3 && mode_r == 2'h1 && odd) begin
        if (|(i_fl_wdata & ~lock_r)) begin
          wr_err_r <= 1'b1;
        end else begin
          lock_r <= i_fl_wdata;
        end
      end else if (step_r == 2'h3 && mode_r == 2'h3 && lo == 8'hF0) begin
        blk_open_r <= 1'b1;
      end else if (step_r == 2'h0 && i_fl_from_flash && i_fl_absolute) begin
        if (i_fl_wdata == D_CODESUS) begin
          code_open_r <= 1'b1;
        end else if (i_fl_wdata == D_CODERES) begin
          code_open_r <= 1'b0;
        end
      end
    end else if (i_fl_re && step_r == 2'h3) begin
      step_r <= 2'h0;
    end
  end
  // ------------------------------------------------------------------
  // Read answer one cycle after the strobe, toggling otherwise
  // ------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_fl_rdata <= 16'hA5A5;
    end else if (i_fl_re) begin
      if (step_r == 2'h3 && mode_r == 2'h2 && odd) begin
        o_fl_rdata <= lock_r;
      end else if (step_r != 2'h0) begin
        o_fl_rdata <= 16'h0000;
      end else if (!lock_r[15] && !code_open_r && !i_fl_from_flash) begin
        o_fl_rdata <= 16'h009B;
      end else begin
        o_fl_rdata <= ~i_fl_addr[15:0];
      end
    end else begin
      o_fl_rdata <= ~o_fl_rdata;
    end
  end
endmodule : fcp_dev_model
`default_nettype wire

// ### bench/fcp_host_tb.sv
`timescale 1ns/10ps
`default_nettype none
module fcp_host_tb;
  import fcp_pkg::*;
  localparam logic [23:0] BASE = 24'h05D234;
  localparam logic [23:0] CMA  = {BASE[23:14], CA_A};
  localparam logic [23:0] CMB  = {BASE[23:14], CA_B};
  localparam logic [23:0] ODA  = {BASE[23:2], ODD_LOW};
  logic        clk = 1'b0, rst_n = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'hF;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, rs;
  logic [23:0] fl_addr;
  logic [15:0] fl_wdata, fl_rdata;
  logic        fl_we, fl_re, fl_ff, fl_abs, sc_en, sc_low, sc_seg;
  logic [47:0] wq[$];
  logic [31:0] v;
  int          failures = 0, n_compared = 0;
  always #4 clk = ~clk;
  fcp_host #(.P_BLK_WIN_CYC(40)) dut_u (
    .i_clk(clk), .i_rst_n(rst_n), .i_awaddr(awaddr), .i_awvalid(awvalid),
    .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb),
    .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
    .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
    .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .o_fl_addr(fl_addr), .o_fl_wdata(fl_wdata), .o_fl_we(fl_we),
    .o_fl_re(fl_re), .o_fl_from_flash(fl_ff), .o_fl_absolute(fl_abs),
    .i_fl_rdata(fl_rdata), .o_internal_flash_enable(sc_en),
    .o_low_window_move(sc_low), .o_segmentation_off(sc_seg));
  fcp_dev_model model_u (
    .i_clk(clk), .i_rst_n(rst_n), .i_fl_addr(fl_addr),
    .i_fl_wdata(fl_wdata), .i_fl_we(fl_we), .i_fl_re(fl_re),
    .i_fl_from_flash(fl_ff), .i_fl_absolute(fl_abs), .o_fl_rdata(fl_rdata));
  // Flash write cycles are logged on the settled half of the clock
  always @(negedge clk) begin
    if (fl_we === 1'b1) wq.push_back({6'h0, fl_ff, fl_abs, fl_addr, fl_wdata});
  end
  function automatic logic [47:0] fw(input logic f, input logic [23:0] a,
                                     input logic [15:0] d);
    return {6'h0, f, f, a, d};
  endfunction : fw
  task automatic stop_test();
    $display("Compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [47:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    hb = 1'b0;
    @(posedge clk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (!hb) begin
      @(negedge clk);
      ha = awvalid & awready;
      hw = wvalid & wready;
      hb = bvalid & bready;
      if (hb) rs = bresp;
      @(posedge clk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hb) bready <= 1'b0;
    end
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
    logic ha, hr;
    hr = 1'b0;
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (!hr) begin
      @(negedge clk);
      ha = arvalid & arready;
      hr = rvalid & rready;
      d = rdata;
      rs = rresp;
      @(posedge clk);
      if (ha) arvalid <= 1'b0;
      if (hr) rready <= 1'b0;
    end
  endtask : axi_rd
  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
    logic [31:0] d;
    axi_rd(a, d);
    chk(nm, {16'h0, d}, {16'h0, e});
  endtask : rchk
  task automatic run_op(input logic [3:0] op, input int nw);
    int n;
    wq.delete();
    axi_wr(OFF_CTRL, {28'h0, op});
    repeat (4) @(posedge clk);
    v = 32'h1;
    n = 0;
    while (v[STAT_BUSY] !== 1'b0 && n < 60) begin
      axi_rd(OFF_STAT, v);
      n++;
    end
    chk("busy_done", 48'(n < 60), 48'h1);
    chk("n_writes", 48'(wq.size()), 48'(nw));
  endtask : run_op
  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
  endtask : do_reset
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    $display("Error watchdog expected done seen hang");
    stop_test();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rchk("scfg", OFF_SCFG, 32'h6);
    chk("scfg_pins", {45'h0, sc_seg, sc_low, sc_en}, 48'h6);
    rchk("data", OFF_DATA, 32'hFFFF);
    rchk("addr", OFF_ADDR, 32'h0);
    axi_rd(8'h18, v);
    chk("rd_unmapped", {46'h0, rs}, {46'h0, RESP_SLVERR});
    axi_wr(8'h18, 32'h0);
    chk("wr_unmapped", {46'h0, rs}, {46'h0, RESP_SLVERR});
    $display("Test reset done");
    axi_wr(OFF_ADDR, {8'h0, BASE});
    axi_wr(OFF_DATA, 32'h7FFE);
    run_op(4'h2, 4);
    chk("sl_w0", wq[0], fw(1'b0, CMA, D_UNLK1));
    chk("sl_w1", wq[1], fw(1'b0, CMB, D_UNLK2));
    chk("sl_w2", wq[2], fw(1'b0, CMA, D_SETLK));
    chk("sl_w3", wq[3], fw(1'b0, ODA, 16'h7FFE));
    run_op(4'h3, 3);
    rchk("lock_rd", OFF_RDAT, 32'h7FFE);
    axi_rd(OFF_STAT, v);
    chk("stat_fsb3", 48'(v[STAT_FSB3]), 48'h1);
    $display("Test lock done");
    run_op(4'h8, 0);
    rchk("poll_prot", OFF_RDAT, 32'h009B);
    run_op(4'h5, 1);
    chk("cs_w", wq[0], fw(1'b1, BASE, D_CODESUS));
    run_op(4'h8, 0);
    rchk("poll_open", OFF_RDAT, {16'h0, ~BASE[15:0]});
    run_op(4'h6, 1);
    chk("cr_w", wq[0], fw(1'b1, BASE, D_CODERES));
    run_op(4'h8, 0);
    rchk("poll_relock", OFF_RDAT, 32'h009B);
    run_op(4'h4, 4);
    chk("bs_w3", wq[3], fw(1'b0, BASE, D_BLKSUS2));
    $display("Test code lock done");
    run_op(4'h1, 1);
    chk("res_w", wq[0], fw(1'b0, BASE, D_RESUME));
    run_op(4'h7, 1);
    chk("blk_w", wq[0], fw(1'b0, BASE, D_RESUME));
    axi_rd(OFF_STAT, v);
    chk("win_open", 48'(v[STAT_WIN]), 48'h0);
    repeat (60) @(posedge clk);
    axi_rd(OFF_STAT, v);
    chk("win_shut", 48'(v[STAT_WIN]), 48'h1);
    run_op(4'h7, 0);
    chk("blk_err", 48'(v[STAT_ERR]), 48'h1);
    run_op(4'h9, 0);
    chk("bad_op", 48'(v[STAT_ERR]), 48'h1);
    run_op(4'h0, 0);
    chk("none_op", 48'(v[STAT_ERR]), 48'h1);
    $display("Test erase window done");
    axi_wr(OFF_DATA, 32'hFFFE);
    run_op(4'h2, 4);
    run_op(4'h3, 3);
    rchk("lock_kept", OFF_RDAT, 32'h7FFE);
    axi_wr(OFF_SCFG, 32'h0);
    repeat (2) @(posedge clk);
    chk("scfg_0", {45'h0, sc_seg, sc_low, sc_en}, 48'h0);
    axi_wr(OFF_SCFG, 32'h1);
    repeat (2) @(posedge clk);
    chk("scfg_1", {45'h0, sc_seg, sc_low, sc_en}, 48'h1);
    $display("Test config done");
    run_op(4'h5, 1);
    do_reset();
    rchk("scfg_rst", OFF_SCFG, 32'h6);
    run_op(4'h8, 0);
    rchk("poll_rst", OFF_RDAT, 32'h009B);
    $display("Test second reset done");
    stop_test();
  end
endmodule : fcp_host_tb
`default_nettype wire
